// >>> verilog/gfse_pkg.sv
// Package with the register map, field layout, state codes and carriers of the geofence state evaluator.
`default_nettype none
package gfse_pkg;
    localparam int unsigned AREAS   = 4;
    localparam int unsigned COORD_W = 16;
    localparam int unsigned LVL_W   = 3;
    localparam int unsigned ADDR_W  = 8;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_IO_SEL    = 8'h04;
    localparam logic [7:0] OFF_REPORT    = 8'h08;
    localparam logic [7:0] OFF_INT_STAT  = 8'h0C;
    localparam logic [7:0] OFF_INT_MASK  = 8'h10;
    localparam logic [7:0] OFF_EPOCH_CNT = 8'h14;
    localparam logic [7:0] OFF_AREA_BASE = 8'h20;
    localparam logic [7:0] AREA_STRIDE   = 8'h08;
    localparam logic [7:0] OFF_AREA_RAD  = 8'h04;

    localparam int unsigned CTRL_EN_LSB  = 0;
    localparam int unsigned CTRL_POL_BIT = 4;
    localparam int unsigned CTRL_LVL_LSB = 8;
    localparam int unsigned REP_COMB_LSB = 8;
    localparam int unsigned IO_SEL_W     = 5;

    localparam int unsigned INT_REPORT = 0;
    localparam int unsigned INT_CHANGE = 1;
    localparam int unsigned INT_W      = 2;

    localparam logic [3:0]       RST_AREA_EN = 4'h0;
    localparam logic [2:0]       RST_LVL     = 3'h1;
    localparam logic [4:0]       RST_IO_SEL  = 5'h03;
    localparam logic [1:0]       RST_INT     = 2'h0;
    localparam logic [31:0]      RD_ZERO     = 32'h0000_0000;

    typedef enum logic [1:0] {
        FENCE_UNKNOWN,
        FENCE_INSIDE,
        FENCE_OUTSIDE
    } gfse_state_e;

    typedef struct packed {
        logic                       valid;
        logic signed [COORD_W-1:0]  east;
        logic signed [COORD_W-1:0]  north;
        logic [COORD_W-1:0]         sigma;
    } gfse_pos_s;
endpackage
`default_nettype wire

// >>> verilog/gfse_evaluator.sv
// Geofence state evaluator with an APB register file, interrupt and status pin.
//
// Design decisions made here: the address map and the APB slave port.
`default_nettype none
// Behaviour
// (RL1) Four circular areas, each with own state.
// (RL2) Evaluate only while some area is enabled.
// (RL3) Each epoch classify area: inside, outside, unknown.
// (RL4) Unknown without valid fix or ambiguous uncertainty.
// (RL5) Uncertainty equals sigma times confidence level.
// (RL6) Combined inside if inside any area.
// (RL7) Combined outside only if outside all.
// (RL8) Combined unknown in every other case.
// (RL9) Publish area and combined states each epoch.
// (RL10) Status pin follows the combined state.
// (RL11) Combined unknown always drives pin high.
// (RL12) Pin high in backup mode or reset.
// (RL13) Polarity chooses meaning of low level.
// (RL14) Software selects io_line_three by index; the code only stores io_sel_reg and reads it back, and drives no such line.
// (RL15) Inside/outside by distance against radius plus uncertainty.
module gfse_evaluator #(
    parameter int unsigned NUM_AREAS = gfse_pkg::AREAS
) (
    input  wire logic                          CORE_CLK,
    input  wire logic                          RST,
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [gfse_pkg::ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]                   PWDATA,
    output logic [31:0]                        PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    input  wire logic                          EPOCH_STB,
    input  wire gfse_pkg::gfse_pos_s           POS,
    input  wire logic                          BACKUP_MODE,
    output logic                               FENCE_PIN,
    output logic                               IRQ
);
    localparam int unsigned CW = gfse_pkg::COORD_W;
    localparam int unsigned NA = NUM_AREAS;

    logic [NA-1:0]                 area_en_reg;
    logic                          fence_pin_polarity_reg;
    logic [gfse_pkg::LVL_W-1:0]    sigma_lvl_reg;
    logic [gfse_pkg::IO_SEL_W-1:0] io_sel_reg;
    logic signed [CW-1:0]          ctr_e_reg [NA];
    logic signed [CW-1:0]          ctr_n_reg [NA];
    logic [CW-1:0]                 rad_reg   [NA];
    gfse_pkg::gfse_state_e         area_st_reg [NA];
    gfse_pkg::gfse_state_e         comb_st_reg;
    logic [gfse_pkg::INT_W-1:0]    int_stat_reg;
    logic [gfse_pkg::INT_W-1:0]    int_mask_reg;
    logic [15:0]                   epoch_cnt_reg;
    logic                          pin_reg;
    logic [31:0]                   prdata_next;
    logic [31:0]                   prdata_reg;
    logic                          pslverr_reg;
    logic                          hit_next;

    gfse_pkg::gfse_state_e         area_eval [NA];
    gfse_pkg::gfse_state_e         comb_next;
    logic [NA-1:0]                 is_in;
    logic [NA-1:0]                 is_out;
    logic                          evaluate;
    logic [gfse_pkg::INT_W-1:0]    int_set;
    logic                          wr_en;
    logic                          setup_ph;

    assign wr_en    = PSEL & PENABLE & PWRITE;
    assign setup_ph = PSEL & ~PENABLE;
    assign PREADY   = 1'b1;
    assign evaluate = EPOCH_STB & (|area_en_reg); // [RL2]

    // Per-area geometric decision on squared distances.
    for (genvar i = 0; i < NA; i++) begin : g_area // [RL1]
        logic signed [CW:0]     dx;
        logic signed [CW:0]     dy;
        logic signed [2*CW+1:0] sq_e;
        logic signed [2*CW+1:0] sq_n;
        logic [2*CW+2:0]        dsq;
        logic [CW+2:0]          unc;
        logic [CW+3:0]          outer;
        logic [CW+2:0]          inner;
        logic                   inner_ok;
        logic [2*CW+7:0]        outer_sq;
        logic [2*CW+5:0]        inner_sq;

        assign dx       = {POS.east[CW-1], POS.east} - {ctr_e_reg[i][CW-1], ctr_e_reg[i]};
        assign dy       = {POS.north[CW-1], POS.north} - {ctr_n_reg[i][CW-1], ctr_n_reg[i]};
        assign sq_e     = dx * dx;
        assign sq_n     = dy * dy;
        assign dsq      = {1'b0, sq_e[2*CW+1:0]} + {1'b0, sq_n[2*CW+1:0]};
        assign unc      = (CW + 3)'(POS.sigma * sigma_lvl_reg); // [RL5]
        assign outer    = {4'h0, rad_reg[i]} + {1'b0, unc};
        assign inner_ok = ({3'h0, rad_reg[i]} >= unc);
        assign inner    = {3'h0, rad_reg[i]} - unc;
        assign outer_sq = outer * outer;
        assign inner_sq = inner * inner;
        assign is_in[i]  = POS.valid & inner_ok & ({3'h0, dsq} <= inner_sq); // [RL15]
        assign is_out[i] = POS.valid & ({5'h00, dsq} > outer_sq); // [RL15]

        // Three-way state of one area from its two distance tests.
        always_comb begin
            if (is_in[i]) begin
                area_eval[i] = gfse_pkg::FENCE_INSIDE; // [RL3]
            end else if (is_out[i]) begin
                area_eval[i] = gfse_pkg::FENCE_OUTSIDE;
            end else begin
                area_eval[i] = gfse_pkg::FENCE_UNKNOWN; // [RL4]
            end
        end
    end

    // Union of the enabled areas.
    always_comb begin
        if (|(is_in & area_en_reg)) begin
            comb_next = gfse_pkg::FENCE_INSIDE; // [RL6]
        end else if ((|area_en_reg) && ((is_out & area_en_reg) == area_en_reg)) begin
            comb_next = gfse_pkg::FENCE_OUTSIDE; // [RL7]
        end else begin
            comb_next = gfse_pkg::FENCE_UNKNOWN; // [RL8]
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            area_en_reg            <= gfse_pkg::RST_AREA_EN;
            fence_pin_polarity_reg <= 1'b0;
            sigma_lvl_reg          <= gfse_pkg::RST_LVL;
            io_sel_reg             <= gfse_pkg::RST_IO_SEL;
            int_mask_reg           <= gfse_pkg::RST_INT;
        end else if (wr_en) begin
            case (PADDR)
                gfse_pkg::OFF_CTRL: begin
                    area_en_reg            <= PWDATA[gfse_pkg::CTRL_EN_LSB +: NA];
                    fence_pin_polarity_reg <= PWDATA[gfse_pkg::CTRL_POL_BIT];
                    sigma_lvl_reg          <= PWDATA[gfse_pkg::CTRL_LVL_LSB +: gfse_pkg::LVL_W];
                end
                gfse_pkg::OFF_IO_SEL: begin
                    io_sel_reg <= PWDATA[gfse_pkg::IO_SEL_W-1:0]; // [RL14]
                end
                gfse_pkg::OFF_INT_MASK: begin
                    int_mask_reg <= PWDATA[gfse_pkg::INT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Area geometry registers.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < NA; i++) begin
                ctr_e_reg[i] <= '0;
                ctr_n_reg[i] <= '0;
                rad_reg[i]   <= '0;
            end
        end else if (wr_en) begin
            for (int i = 0; i < NA; i++) begin
                if (PADDR == 8'(gfse_pkg::OFF_AREA_BASE + 8'(i) * gfse_pkg::AREA_STRIDE)) begin
                    ctr_e_reg[i] <= PWDATA[CW-1:0];
                    ctr_n_reg[i] <= PWDATA[2*CW-1:CW];
                end
                if (PADDR == 8'(gfse_pkg::OFF_AREA_BASE + 8'(i) * gfse_pkg::AREA_STRIDE
                                + gfse_pkg::OFF_AREA_RAD)) begin
                    rad_reg[i] <= PWDATA[CW-1:0];
                end
            end
        end
    end

    // Per-epoch state report.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < NA; i++) begin
                area_st_reg[i] <= gfse_pkg::FENCE_UNKNOWN;
            end
            comb_st_reg   <= gfse_pkg::FENCE_UNKNOWN;
            epoch_cnt_reg <= 16'h0000;
        end else if (evaluate) begin
            for (int i = 0; i < NA; i++) begin
                area_st_reg[i] <= area_en_reg[i] ? area_eval[i] : gfse_pkg::FENCE_UNKNOWN; // [RL9]
            end
            comb_st_reg   <= comb_next; // [RL9]
            epoch_cnt_reg <= epoch_cnt_reg + 16'h0001;
        end
    end

    // Status pin drive.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pin_reg <= 1'b1; // [RL12]
        end else if (BACKUP_MODE) begin
            pin_reg <= 1'b1; // [RL12]
        end else begin
            case (comb_st_reg) // [RL10]
                gfse_pkg::FENCE_INSIDE:  pin_reg <= fence_pin_polarity_reg; // [RL13]
                gfse_pkg::FENCE_OUTSIDE: pin_reg <= ~fence_pin_polarity_reg; // [RL13]
                default:                 pin_reg <= 1'b1; // [RL11]
            endcase
        end
    end
    assign FENCE_PIN = pin_reg;

    // Sticky interrupt flags, a new event wins over a clear.
    always_comb begin
        int_set                      = '0;
        int_set[gfse_pkg::INT_REPORT] = evaluate;
        int_set[gfse_pkg::INT_CHANGE] = evaluate & (comb_next != comb_st_reg);
    end

    // Flag register, cleared by writing ones to it.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            int_stat_reg <= gfse_pkg::RST_INT;
        end else if (wr_en && PADDR == gfse_pkg::OFF_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~PWDATA[gfse_pkg::INT_W-1:0]) | int_set;
        end else begin
            int_stat_reg <= int_stat_reg | int_set;
        end
    end

    // Level interrupt, high while an unmasked flag is set.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |((int_stat_reg | int_set) & int_mask_reg);
        end
    end

    // Read mux and address decode.
    always_comb begin
        prdata_next = gfse_pkg::RD_ZERO;
        hit_next    = 1'b1;
        case (PADDR)
            gfse_pkg::OFF_CTRL: begin
                prdata_next[gfse_pkg::CTRL_EN_LSB +: NA]               = area_en_reg;
                prdata_next[gfse_pkg::CTRL_POL_BIT]                    = fence_pin_polarity_reg;
                prdata_next[gfse_pkg::CTRL_LVL_LSB +: gfse_pkg::LVL_W] = sigma_lvl_reg;
            end
            gfse_pkg::OFF_IO_SEL: begin
                prdata_next[gfse_pkg::IO_SEL_W-1:0] = io_sel_reg;
            end
            gfse_pkg::OFF_REPORT: begin
                for (int i = 0; i < NA; i++) begin
                    prdata_next[2*i +: 2] = area_st_reg[i];
                end
                prdata_next[gfse_pkg::REP_COMB_LSB +: 2] = comb_st_reg;
            end
            gfse_pkg::OFF_INT_STAT: begin
                prdata_next[gfse_pkg::INT_W-1:0] = int_stat_reg;
            end
            gfse_pkg::OFF_INT_MASK: begin
                prdata_next[gfse_pkg::INT_W-1:0] = int_mask_reg;
            end
            gfse_pkg::OFF_EPOCH_CNT: begin
                prdata_next[15:0] = epoch_cnt_reg;
            end
            default: begin
                hit_next = 1'b0;
                for (int i = 0; i < NA; i++) begin
                    if (PADDR == 8'(gfse_pkg::OFF_AREA_BASE + 8'(i) * gfse_pkg::AREA_STRIDE)) begin
                        prdata_next = {ctr_n_reg[i], ctr_e_reg[i]};
                        hit_next    = 1'b1;
                    end
                    if (PADDR == 8'(gfse_pkg::OFF_AREA_BASE + 8'(i) * gfse_pkg::AREA_STRIDE
                                    + gfse_pkg::OFF_AREA_RAD)) begin
                        prdata_next = {16'h0000, rad_reg[i]};
                        hit_next    = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data is taken in the setup cycle and shown in the access cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            prdata_reg <= gfse_pkg::RD_ZERO;
        end else if (setup_ph && !PWRITE) begin
            prdata_reg <= prdata_next;
        end else begin
            prdata_reg <= gfse_pkg::RD_ZERO;
        end
    end

    // Error response for an unmapped address, shown in the access cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            pslverr_reg <= ~hit_next;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end
    assign PRDATA  = prdata_reg;
    assign PSLVERR = pslverr_reg;
endmodule // gfse_evaluator
`default_nettype wire

// >>> testbench/gfse_evaluator_asserts.sv
// Checker of the evaluator ports with its bind statement.
`default_nettype none
module gfse_evaluator_asserts (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        EPOCH_STB,
    input wire logic        BACKUP_MODE,
    input wire logic        FENCE_PIN,
    input wire logic        IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic acc;
    logic rd_rep;
    logic wr_ctrl;
    logic wr_irq;
    logic pol_q;
    assign acc = PSEL && PENABLE;
    assign rd_rep = acc && !PWRITE && (PADDR == gfse_pkg::OFF_REPORT);
    assign wr_ctrl = acc && PWRITE && (PADDR == gfse_pkg::OFF_CTRL);
    assign wr_irq = acc && PWRITE && (PADDR == gfse_pkg::OFF_INT_STAT || PADDR == gfse_pkg::OFF_INT_MASK);
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pol_q <= 1'b0;
        end else if (wr_ctrl) begin
            pol_q <= PWDATA[gfse_pkg::CTRL_POL_BIT];
        end
    end
    a_reset_pin_high: assert property ($fell(RST) |-> FENCE_PIN && !IRQ) else $error("pin low after reset");
    a_backup_pin_high: assert property ($past(BACKUP_MODE) |-> FENCE_PIN) else $error("pin low in backup");
    a_unknown_pin_high: assert property (rd_rep && PRDATA[9:8] == 2'h0 && !$past(EPOCH_STB) |-> FENCE_PIN)
        else $error("pin low while unknown");
    a_inside_pin_pol: assert property (rd_rep && PRDATA[9:8] == 2'h1 && !$past(EPOCH_STB) && !$past(wr_ctrl)
        && !$past(BACKUP_MODE) |-> FENCE_PIN == pol_q) else $error("pin wrong while inside");
    a_outside_pin_pol: assert property (rd_rep && PRDATA[9:8] == 2'h2 && !$past(EPOCH_STB) && !$past(wr_ctrl)
        && !$past(BACKUP_MODE) |-> FENCE_PIN == !pol_q) else $error("pin wrong while outside");
    a_ready_in_access: assert property (acc |-> PREADY) else $error("ready low in access");
    a_idle_bus_quiet: assert property (!acc |-> PRDATA == 32'h0000_0000 && !PSLVERR) else $error("bus not quiet");
    a_unmapped_error: assert property (acc && PADDR == 8'h18 |-> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("no error on unmapped");
    a_irq_rise_cause: assert property ($rose(IRQ) |-> $past(EPOCH_STB) || $past(wr_irq) || $past(wr_irq, 2))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(wr_irq) || $past(wr_irq, 2)) else $error("irq fell alone");
    c_inside_seen: cover property (rd_rep && PRDATA[9:8] == 2'h1);
    c_outside_seen: cover property (rd_rep && PRDATA[9:8] == 2'h2);
    c_irq_rose: cover property ($rose(IRQ));
    c_backup_seen: cover property (BACKUP_MODE && FENCE_PIN);
endmodule // gfse_evaluator_asserts
bind gfse_evaluator gfse_evaluator_asserts gfse_evaluator_asserts_inst (.CORE_CLK(CORE_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .EPOCH_STB(EPOCH_STB), .BACKUP_MODE(BACKUP_MODE),
    .FENCE_PIN(FENCE_PIN), .IRQ(IRQ));
`default_nettype wire

// >>> testbench/gfse_host_model.sv
// Host model that reaches the evaluator registers as an APB master.
`default_nettype none
module gfse_host_model (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic ok);
        int i;
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 64 && !ok; i++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // gfse_host_model
`default_nettype wire

// >>> testbench/gfse_evaluator_tb_top.sv
// Self-checking testbench of the geofence state evaluator.
`default_nettype none
module gfse_evaluator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                CORE_CLK;
    logic                RST;
    logic                PSEL;
    logic                PENABLE;
    logic                PWRITE;
    logic [7:0]          PADDR;
    logic [31:0]         PWDATA;
    logic [31:0]         PRDATA;
    logic                PREADY;
    logic                PSLVERR;
    logic                EPOCH_STB;
    gfse_pkg::gfse_pos_s POS;
    logic                BACKUP_MODE;
    logic                FENCE_PIN;
    logic                IRQ;
    int                  bad_count;
    int                  cmp_count;
    int                  n_ep;
    logic                pol;
    logic [31:0]         q;
    logic                err;
    logic [15:0]         ae [4] = '{16'h0000, 16'h03E8, 16'h0000, 16'hFC18};
    logic [15:0]         an [4] = '{16'h0000, 16'h0000, 16'h03E8, 16'hFC18};
    logic [15:0]         ar [4] = '{16'h0064, 16'h0064, 16'h0032, 16'h000A};
    logic [15:0]         te [7] = '{16'h0, 16'h5A, 16'h5F, 16'h6E, 16'h6F, 16'h1F4, 16'h0};
    logic [15:0]         tn [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1F4, 16'h0};
    logic [31:0]         tx [7] = '{32'h1A9, 32'h1A9, 32'h0A8, 32'h0A8, 32'h2AA, 32'h2AA, 32'h000};
    logic [6:0]          tv = 7'h3F;
    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    gfse_evaluator gfse_evaluator_inst (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EPOCH_STB(EPOCH_STB), .POS(POS), .BACKUP_MODE(BACKUP_MODE), .FENCE_PIN(FENCE_PIN), .IRQ(IRQ));
    gfse_host_model gfse_host_model_inst (.clk(CORE_CLK), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR),
        .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        gfse_host_model_inst.xfer(w, a, d, q, err, ok);
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t bus wait ran out", $time);
            end_of_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    task automatic strobe(input logic v, input logic [15:0] e, input logic [15:0] n);
        @(posedge CORE_CLK);
        POS <= {v, e, n, 16'h0005};
        EPOCH_STB <= 1'b1;
        @(posedge CORE_CLK);
        EPOCH_STB <= 1'b0;
        POS <= ~{v, e, n, 16'h0005};
        repeat (2) @(posedge CORE_CLK);
    endtask
    task automatic ep(input logic v, input logic [15:0] e, input logic [15:0] n, input logic [31:0] exp);
        logic p;
        p = (exp[9:8] == 2'h1) ? pol : ((exp[9:8] == 2'h2) ? ~pol : 1'b1);
        strobe(v, e, n);
        n_ep++;
        check(32'(FENCE_PIN), 32'(p));
        rd(gfse_pkg::OFF_REPORT, exp);
    endtask
    initial begin
        RST = 1'b1;
        EPOCH_STB = 1'b0;
        POS = '0;
        BACKUP_MODE = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        n_ep = 0;
        pol = 1'b0;
        repeat (12) @(posedge CORE_CLK);
        RST <= 1'b0;
        check(32'(FENCE_PIN), 32'h1);
        rd(gfse_pkg::OFF_CTRL, 32'h100);
        rd(gfse_pkg::OFF_IO_SEL, 32'h03);
        rd(gfse_pkg::OFF_REPORT, 32'h0);
        acc(1'b0, 8'h18, 32'h0);
        check(32'(err), 32'h1);
        acc(1'b1, gfse_pkg::OFF_REPORT, 32'hFFFF_FFFF);
        rd(gfse_pkg::OFF_REPORT, 32'h0);
        strobe(1'b1, 16'h0, 16'h0);
        rd(gfse_pkg::OFF_EPOCH_CNT, 32'h0);
        $display("test reset and idle done");
        acc(1'b1, gfse_pkg::OFF_IO_SEL, 32'h03);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, gfse_pkg::OFF_AREA_BASE + gfse_pkg::AREA_STRIDE * 8'(i), {an[i], ae[i]});
            acc(1'b1, gfse_pkg::OFF_AREA_BASE + gfse_pkg::AREA_STRIDE * 8'(i) + gfse_pkg::OFF_AREA_RAD,
                {16'h0, ar[i]});
        end
        acc(1'b1, gfse_pkg::OFF_INT_MASK, 32'h1);
        rd(gfse_pkg::OFF_INT_MASK, 32'h1);
        rd(gfse_pkg::OFF_AREA_BASE + gfse_pkg::AREA_STRIDE, {an[1], ae[1]});
        rd(gfse_pkg::OFF_AREA_BASE + gfse_pkg::AREA_STRIDE + gfse_pkg::OFF_AREA_RAD, {16'h0, ar[1]});
        acc(1'b1, gfse_pkg::OFF_CTRL, 32'h20F);
        for (int i = 0; i < 7; i++) begin
            ep(tv[i], te[i], tn[i], tx[i]);
        end
        rd(gfse_pkg::OFF_EPOCH_CNT, 32'(n_ep));
        rd(gfse_pkg::OFF_INT_STAT, 32'h3);
        check(32'(IRQ), 32'h1);
        acc(1'b1, gfse_pkg::OFF_INT_STAT, 32'h3);
        repeat (2) @(posedge CORE_CLK);
        check(32'(IRQ), 32'h0);
        $display("test area table done");
        acc(1'b1, gfse_pkg::OFF_CTRL, 32'h10F);
        ep(1'b1, 16'h5F, 16'h0, 32'h1A9);
        acc(1'b1, gfse_pkg::OFF_CTRL, 32'h11F);
        pol = 1'b1;
        ep(1'b1, 16'h0, 16'h0, 32'h1A9);
        ep(1'b1, 16'h1F4, 16'h1F4, 32'h2AA);
        BACKUP_MODE <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        check(32'(FENCE_PIN), 32'h1);
        BACKUP_MODE <= 1'b0;
        $display("test level polarity backup done");
        acc(1'b1, gfse_pkg::OFF_INT_MASK, 32'h0);
        acc(1'b1, gfse_pkg::OFF_INT_STAT, 32'h3);
        acc(1'b1, gfse_pkg::OFF_CTRL, 32'h102);
        pol = 1'b0;
        ep(1'b1, 16'h0, 16'h0, 32'h208);
        check(32'(IRQ), 32'h0);
        rd(gfse_pkg::OFF_INT_STAT, 32'h1);
        rd(gfse_pkg::OFF_EPOCH_CNT, 32'(n_ep));
        $display("test disabled areas done");
        end_of_test();
    end
endmodule // gfse_evaluator_tb_top
`default_nettype wire
